// ### mms_pkg.sv
package mms_pkg;
    // apb byte addresses
    localparam logic [7:0] MMS_CTRL_OFS = 8'h00;
    localparam logic [7:0] MMS_AXIS_OFS = 8'h04;
    localparam logic [7:0] MMS_CHKB_OFS = 8'h08;
    localparam logic [7:0] MMS_STAT_OFS = 8'h0C;
    localparam logic [7:0] MMS_IRQ_OFS = 8'h10;
    localparam logic [7:0] MMS_MASK_OFS = 8'h14;
    localparam logic [7:0] MMS_PROG_OFS = 8'h18;
    // channel control word: byte 100..103 mapped to lanes
    localparam int MMS_SEL_AUTO = 0;
    localparam int MMS_SEL_MBE = 1;
    localparam int MMS_SEL_JOG = 2;
    localparam int MMS_SEL_HOME = 10;
    localparam int MMS_SEL_SBL = 12;
    localparam int MMS_SKIP = 16;
    localparam int MMS_RDINH = 17;
    localparam int MMS_TEST = 18;
    localparam int MMS_START = 25;
    localparam int MMS_STOP = 27;
    localparam int MMS_RESET = 28;
    // axis word
    localparam int MMS_AX_MINUS = 6;
    localparam int MMS_AX_PLUS = 7;
    localparam int MMS_AX_DECEL = 15;
    // checkback word: byte 120 lane 0, byte 121 lane 1
    localparam int MMS_CB_AUTO = 0;
    localparam int MMS_CB_MBE = 1;
    localparam int MMS_CB_JOG = 2;
    localparam int MMS_CB_HOME = 10;
    // status byte 125
    localparam int MMS_ST_RUN = 0;
    localparam int MMS_ST_WAIT = 1;
    localparam int MMS_ST_INTR = 3;
    localparam int MMS_ST_ABORT = 4;
    // interrupt events
    localparam int MMS_EV_REFUSE = 0;
    localparam int MMS_EV_DONE = 1;
    localparam int MMS_EV_HOMED = 2;
    localparam int MMS_EV_STOP = 3;
    localparam logic [31:0] MMS_ZERO = 32'h0000_0000;
    localparam logic [3:0] MMS_BLK_CYCLES = 4'h8;
    typedef enum logic [1:0] {MMS_M_NONE, MMS_M_AUTO, MMS_M_MBE, MMS_M_HOME} mms_mode_t;
    typedef enum logic [1:0] {MMS_P_ABORT, MMS_P_RUN, MMS_P_WAIT, MMS_P_INTR} mms_prog_t;
endpackage

// ### mms_edge.sv
`timescale 1ns/1ns
module mms_edge import mms_pkg::*; (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic lvl, // level in
    output logic rise // one-cycle pulse on rising level
);
    typedef struct packed {logic prev;} mms_edge_st_t;
    mms_edge_st_t s_q, s_d;
    always_comb
    begin
        s_d = s_q;
        s_d.prev = lvl;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end
    assign rise = lvl & ~s_q.prev;
endmodule

// ### mms_blk.sv
`timescale 1ns/1ns
module mms_blk import mms_pkg::*; (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic go, // begin one block
    input wire logic halt, // abandon current block
    output logic busy, // block executing
    output logic done // one-cycle pulse, block finished
);
    // stands in for block execution: fixed duration per block
    typedef struct packed {logic [3:0] cnt; logic busy; logic done;} mms_blk_st_t;
    mms_blk_st_t s_q, s_d;
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (halt)
        begin
            s_d.busy = 1'b0;
            s_d.cnt = '0;
        end
        else if (s_q.busy)
        begin
            if (s_q.cnt == MMS_BLK_CYCLES - 4'h1)
            begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
            s_d.cnt = s_q.cnt + 4'h1;
        end
        else if (go)
        begin
            s_d.busy = 1'b1;
            s_d.cnt = '0;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end
    assign busy = s_q.busy;
    assign done = s_q.done;
endmodule

// ### mms_top.sv
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
// Behaviour
// (RULE1) homing submode of jog offered
// (RULE2) host sets jog and homing select bits
// (RULE3) homing active sets jog and homing checkbacks
// (RULE4) direction bit starts homing approach
// (RULE5) host drives deceleration input at cam
// (RULE6) manual block entry runs on start
// (RULE7) host selects manual block entry bit
// (RULE8) manual block entry checkback when active
// (RULE9) automatic needs selected program then start
// (RULE10) host selects automatic bit
// (RULE11) stop halts automatic execution
// (RULE12) read-in inhibit withholds further blocks
// (RULE13) skip bit skips skippable blocks
// (RULE14) automatic checkback when active
// (RULE15) running, waiting, interrupted status flags
// (RULE16) test functions allowed while running
// (RULE17) mode change only in reset or stopped
// (RULE18) refused mode change raises error
// (RULE19) one checkback, only after acceptance
module mms_top import mms_pkg::*; (
    input wire logic pclk, // clock 100 MHz
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic irq, // level interrupt
    output logic [1:0] axis_dir, // registered homing travel, {plus, minus}
    output logic skip_active, // skippable blocks being skipped
    output logic test_active // program test functions on
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] axis;
        mms_mode_t mode;
        mms_prog_t prog;
        logic prog_sel;
        logic homed;
        logic mode_err;
        logic [3:0] irq_st;
        logic [3:0] irq_mask;
        logic [31:0] rdata;
        logic [1:0] dir;
        logic [2:0] blocks_left;
    } mms_st_t;
    mms_st_t s_q, s_d;

    logic start_rise, blk_busy, blk_done, blk_go, blk_halt;
    logic wr, rd, addr_ok;
    mms_mode_t req_mode;

    function automatic logic mms_hit(input logic [7:0] a, input logic [7:0] ofs);
        mms_hit = (a == ofs);
    endfunction

    // requested mode decoded from select bits; homing needs both bits
    function automatic mms_mode_t mms_req(input logic [31:0] c);
        if (c[MMS_SEL_JOG] && c[MMS_SEL_HOME]) // RULE2
            mms_req = MMS_M_HOME;
        else if (c[MMS_SEL_AUTO])
            mms_req = MMS_M_AUTO;
        else if (c[MMS_SEL_MBE])
            mms_req = MMS_M_MBE;
        else
            mms_req = MMS_M_NONE;
    endfunction

    mms_edge u_start (
        .pclk(pclk),
        .presetn(presetn),
        .lvl(s_q.ctrl[MMS_START]),
        .rise(start_rise)
    );

    mms_blk u_blk (
        .pclk(pclk),
        .presetn(presetn),
        .go(blk_go),
        .halt(blk_halt),
        .busy(blk_busy),
        .done(blk_done)
    );

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign addr_ok = mms_hit(paddr, MMS_CTRL_OFS) || mms_hit(paddr, MMS_AXIS_OFS)
        || mms_hit(paddr, MMS_CHKB_OFS) || mms_hit(paddr, MMS_STAT_OFS)
        || mms_hit(paddr, MMS_IRQ_OFS) || mms_hit(paddr, MMS_MASK_OFS)
        || mms_hit(paddr, MMS_PROG_OFS);
    assign req_mode = mms_req(s_q.ctrl);

    // execution only advances in an accepted run mode
    assign blk_halt = (s_q.mode == MMS_M_AUTO && s_q.ctrl[MMS_STOP]) // RULE11
        || s_q.ctrl[MMS_RESET];
    assign blk_go = !blk_halt && (
        (s_q.mode == MMS_M_MBE && start_rise) // RULE6
        || (s_q.mode == MMS_M_AUTO && s_q.prog == MMS_P_RUN
            && !s_q.ctrl[MMS_RDINH])); // RULE12

    function automatic logic [31:0] mms_chkb(input mms_mode_t m);
        logic [31:0] v;
        v = MMS_ZERO;
        case (m) // RULE19
            MMS_M_AUTO: v[MMS_CB_AUTO] = 1'b1; // RULE14
            MMS_M_MBE: v[MMS_CB_MBE] = 1'b1; // RULE8
            MMS_M_HOME:
            begin
                v[MMS_CB_JOG] = 1'b1; // RULE3
                v[MMS_CB_HOME] = 1'b1;
            end
            default: v = MMS_ZERO;
        endcase
        mms_chkb = v;
    endfunction

    function automatic logic [31:0] mms_stat(input mms_prog_t p);
        logic [31:0] v;
        v = MMS_ZERO;
        case (p) // RULE15
            MMS_P_RUN: v[MMS_ST_RUN] = 1'b1;
            MMS_P_WAIT: v[MMS_ST_WAIT] = 1'b1;
            MMS_P_INTR: v[MMS_ST_INTR] = 1'b1;
            default: v[MMS_ST_ABORT] = 1'b1;
        endcase
        mms_stat = v;
    endfunction

    always_comb
    begin
        logic [3:0] ev;
        logic idle;
        ev = 4'h0;
        s_d = s_q;
        idle = (s_q.prog == MMS_P_ABORT || s_q.prog == MMS_P_INTR) && !blk_busy;
        // register writes
        if (wr && mms_hit(paddr, MMS_CTRL_OFS))
            s_d.ctrl = pwdata;
        if (wr && mms_hit(paddr, MMS_AXIS_OFS))
            s_d.axis = pwdata[15:0];
        if (wr && mms_hit(paddr, MMS_MASK_OFS))
            s_d.irq_mask = pwdata[3:0];
        if (wr && mms_hit(paddr, MMS_PROG_OFS))
            s_d.prog_sel = pwdata[0] && s_q.prog == MMS_P_ABORT;
        // mode switching
        if (req_mode != s_q.mode)
        begin
            if (idle || s_q.ctrl[MMS_RESET]) // RULE17
            begin
                s_d.mode = req_mode; // RULE19
                s_d.mode_err = 1'b0;
                s_d.homed = 1'b0;
            end
            else if (!s_q.mode_err)
            begin
                s_d.mode_err = 1'b1; // RULE18
                ev[MMS_EV_REFUSE] = 1'b1;
            end
        end
        else
            s_d.mode_err = 1'b0;
        // automatic single-block toggling is always allowed
        // homing: direction bits drive travel until the cam is reached
        s_d.dir = 2'b00;
        if (s_q.mode == MMS_M_HOME && !s_q.homed) // RULE1
        begin
            s_d.dir = {s_q.axis[MMS_AX_PLUS], s_q.axis[MMS_AX_MINUS]}; // RULE4
            if (s_q.axis[MMS_AX_DECEL] && |s_q.dir) // RULE5
            begin
                s_d.homed = 1'b1;
                s_d.dir = 2'b00;
                ev[MMS_EV_HOMED] = 1'b1;
            end
        end
        // program state
        if (s_q.ctrl[MMS_RESET])
        begin
            s_d.prog = MMS_P_ABORT;
            s_d.prog_sel = 1'b0;
        end
        else if (s_q.mode == MMS_M_AUTO)
        begin
            case (s_q.prog)
                MMS_P_ABORT, MMS_P_INTR:
                    if (start_rise && (s_q.prog_sel || s_q.prog == MMS_P_INTR)) // RULE9
                    begin
                        s_d.prog = MMS_P_RUN;
                        s_d.blocks_left = 3'h7;
                    end
                MMS_P_RUN:
                    if (s_q.ctrl[MMS_STOP]) // RULE11
                    begin
                        s_d.prog = MMS_P_INTR;
                        ev[MMS_EV_STOP] = 1'b1;
                    end
                    else if (s_q.ctrl[MMS_RDINH]) // RULE12
                        s_d.prog = MMS_P_WAIT;
                    else if (blk_done)
                    begin
                        // skipping drops two marked blocks of the program
                        if (s_q.ctrl[MMS_SKIP] && s_q.blocks_left > 3'h2) // RULE13
                            s_d.blocks_left = s_q.blocks_left - 3'h3;
                        else if (s_q.blocks_left != 3'h0)
                            s_d.blocks_left = s_q.blocks_left - 3'h1;
                        if (s_q.blocks_left <= 3'h1 || (s_q.ctrl[MMS_SKIP]
                            && s_q.blocks_left <= 3'h3))
                        begin
                            s_d.prog = MMS_P_ABORT;
                            s_d.prog_sel = 1'b0;
                            ev[MMS_EV_DONE] = 1'b1;
                        end
                        else if (s_q.ctrl[MMS_SEL_SBL])
                            s_d.prog = MMS_P_INTR;
                    end
                MMS_P_WAIT:
                    if (s_q.ctrl[MMS_STOP])
                        s_d.prog = MMS_P_INTR;
                    else if (!s_q.ctrl[MMS_RDINH])
                        s_d.prog = MMS_P_RUN;
                default: s_d.prog = MMS_P_ABORT;
            endcase
        end
        else if (s_q.mode == MMS_M_MBE && blk_done)
            ev[MMS_EV_DONE] = 1'b1;
        // sticky status: clear on read, new events win
        if (rd && mms_hit(paddr, MMS_IRQ_OFS))
            s_d.irq_st = ev;
        else
            s_d.irq_st = s_q.irq_st | ev;
        // read data registered from current state
        s_d.rdata = MMS_ZERO;
        if (rd)
        begin
            case (paddr)
                MMS_CTRL_OFS: s_d.rdata = s_q.ctrl;
                MMS_AXIS_OFS: s_d.rdata = {16'h0000, s_q.axis};
                MMS_CHKB_OFS: s_d.rdata = mms_chkb(s_q.mode);
                MMS_STAT_OFS: s_d.rdata = mms_stat(s_q.prog)
                    | {30'h0000_0000, s_q.mode_err, s_q.homed} << 8;
                MMS_IRQ_OFS: s_d.rdata = {28'h000_0000, s_q.irq_st};
                MMS_MASK_OFS: s_d.rdata = {28'h000_0000, s_q.irq_mask};
                MMS_PROG_OFS: s_d.rdata = {31'h0000_0000, s_q.prog_sel};
                default: s_d.rdata = MMS_ZERO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    // reads take one wait state, writes none: read data lands in rdata at the first access edge
    logic rd_q;
    logic pready_w;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_q <= 1'b0;
        else
            rd_q <= psel && penable && !rd_q && !pready_w;
    end
    assign pready_w = pwrite || rd_q;
    assign pready = psel && penable && pready_w;
    assign pslverr = pready && !addr_ok;
    assign prdata = s_q.rdata;
    assign irq = |(s_q.irq_st & s_q.irq_mask);
    assign axis_dir = s_q.dir;
    assign skip_active = s_q.mode == MMS_M_AUTO && s_q.ctrl[MMS_SKIP];
    assign test_active = s_q.mode == MMS_M_AUTO && s_q.ctrl[MMS_TEST]; // RULE16
endmodule

// ### mms_checker.sv
`timescale 1ns/1ns
module mms_checker import mms_pkg::*; (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pwrite, // apb
    input wire logic [7:0] paddr, // apb
    input wire logic [31:0] pwdata, // apb
    input wire logic [31:0] prdata, // apb
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire logic irq, // interrupt
    input wire logic [1:0] axis_dir, // travel
    input wire logic skip_active, // skip on
    input wire logic test_active // test on
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire wr_go = psel && penable && pwrite;
    wire ctl_w = wr_go && paddr == MMS_CTRL_OFS;
    wire ax_w = wr_go && paddr == MMS_AXIS_OFS;
    wire msk_w = wr_go && paddr == MMS_MASK_OFS;
    a_rdy_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_write_no_wait: assert property (wr_go |-> pready)
        else $error("write waited");
    a_read_one_wait: assert property (psel && !penable && !pwrite ##1 penable |-> !pready ##1 pready)
        else $error("read wait wrong");
    a_err_unmapped: assert property (pready && paddr > MMS_PROG_OFS |-> pslverr)
        else $error("no error on unmapped");
    a_skip_drops: assert property (ctl_w && !pwdata[MMS_SKIP] |=> !skip_active)
        else $error("skip stayed");
    a_test_drops: assert property (ctl_w && !pwdata[MMS_TEST] |=> !test_active)
        else $error("test stayed");
    a_dir_drops: assert property (ax_w && pwdata[7:6] == 2'b00 |-> ##[1:2] axis_dir == 2'b00)
        else $error("travel stayed");
    a_irq_masked: assert property (msk_w && pwdata == MMS_ZERO |=> !irq)
        else $error("masked irq high");
    c_irq: cover property (irq);
    c_ctl: cover property (skip_active && test_active);
    c_dir: cover property (axis_dir == 2'b10);
endmodule
bind mms_top mms_checker u_mms_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .axis_dir(axis_dir),
    .skip_active(skip_active), .test_active(test_active));

// ### mms_host.sv
`timescale 1ns/1ns
module mms_host (
    input wire logic pclk, // clock
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire logic [31:0] prdata, // apb
    output logic psel, // apb
    output logic penable, // apb
    output logic pwrite, // apb
    output logic [7:0] paddr, // apb
    output logic [31:0] pwdata // apb
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines must not look like valid data
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

// ### mms_top_bench.sv
`timescale 1ns/1ns
module mms_top_bench import mms_pkg::*; ;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, skip_active, test_active, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] axis_dir;
    int err_total = 0;
    int comparisons = 0;
    localparam logic [31:0] S_AU = 32'h1 << MMS_SEL_AUTO;
    localparam logic [31:0] S_MB = 32'h1 << MMS_SEL_MBE;
    localparam logic [31:0] S_HO = 32'h1 << MMS_SEL_JOG | 32'h1 << MMS_SEL_HOME;
    localparam logic [31:0] B_GO = 32'h1 << MMS_START;
    localparam logic [31:0] B_PR = 32'h1 << MMS_TEST | 32'h1 << MMS_SKIP | 32'h1 << MMS_RDINH;
    localparam logic [31:0] B_RS = 32'h1 << MMS_RESET;
    logic [31:0] rows [4][2] = '{'{S_AU, 32'h1}, '{S_MB, 32'h2}, '{S_HO, 32'h404}, '{0, 0}};
    mms_top u_mms_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .axis_dir(axis_dir), .skip_active(skip_active),
        .test_active(test_active));
    mms_host u_mms_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    task automatic report_and_stop();
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        u_mms_host.xfer(w, a, d, q, e);
    endtask
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        #100000;
        err_total++;
        report_and_stop();
    end
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        bus(0, MMS_CHKB_OFS, 0);
        chk(q, 32'h0);
        bus(0, 8'h1C, 0);
        chk({q[31:1], e}, 32'h1);
        foreach (rows[i])
        begin
            bus(1, MMS_CTRL_OFS, rows[i][0]);
            bus(0, MMS_CHKB_OFS, 0);
            chk(q, rows[i][1]);
        end
        bus(1, MMS_CTRL_OFS, S_AU);
        bus(1, MMS_PROG_OFS, 32'h1);
        bus(1, MMS_MASK_OFS, 32'hF);
        bus(1, MMS_CTRL_OFS, S_AU | B_GO | B_PR);
        bus(0, MMS_STAT_OFS, 0);
        // inhibit is already set when start lands, so the program waits
        chk(q & 32'h3, 32'h2);
        chk({test_active, skip_active}, 2'b11);
        // change of mode while a program waits must be refused
        bus(1, MMS_CTRL_OFS, S_MB | B_GO | B_PR);
        bus(0, MMS_CHKB_OFS, 0);
        chk(q, 32'h1);
        bus(0, MMS_STAT_OFS, 0);
        chk(q & 32'h200, 32'h200);
        chk(irq, 1'b1);
        repeat (100) @(posedge pclk);
        bus(0, MMS_IRQ_OFS, 0);
        chk(q & 32'h3, 32'h1);
        bus(1, MMS_CTRL_OFS, S_AU | B_GO);
        repeat (100) @(posedge pclk);
        bus(0, MMS_IRQ_OFS, 0);
        chk(q & 32'h2, 32'h2);
        bus(0, MMS_IRQ_OFS, 0);
        #1;
        chk({q[3:0], irq}, 5'h00);
        bus(1, MMS_PROG_OFS, 32'h1);
        bus(1, MMS_CTRL_OFS, S_AU | 32'h1 << MMS_SEL_SBL);
        bus(1, MMS_CTRL_OFS, S_AU | 32'h1 << MMS_SEL_SBL | B_GO);
        repeat (20) @(posedge pclk);
        bus(0, MMS_STAT_OFS, 0);
        chk(q & 32'h1B, 32'h8);
        bus(1, MMS_PROG_OFS, 32'h1);
        bus(1, MMS_CTRL_OFS, S_AU);
        bus(1, MMS_CTRL_OFS, S_AU | B_GO);
        bus(1, MMS_CTRL_OFS, S_AU | B_GO | 32'h1 << MMS_STOP);
        bus(0, MMS_STAT_OFS, 0);
        chk(q & 32'h9, 32'h8);
        bus(0, MMS_IRQ_OFS, 0);
        chk(q & 32'h8, 32'h8);
        bus(1, MMS_CTRL_OFS, S_HO | B_RS);
        bus(1, MMS_CTRL_OFS, S_HO);
        bus(0, MMS_CHKB_OFS, 0);
        chk(q, 32'h404);
        bus(1, MMS_AXIS_OFS, 32'h80);
        repeat (3) @(posedge pclk);
        chk(axis_dir, 2'b10);
        bus(1, MMS_AXIS_OFS, 32'h8080);
        bus(0, MMS_STAT_OFS, 0);
        chk({q[8], axis_dir}, 3'h4);
        bus(1, MMS_AXIS_OFS, 32'h0);
        bus(1, MMS_CTRL_OFS, S_MB | B_RS);
        bus(1, MMS_CTRL_OFS, S_MB);
        bus(0, MMS_IRQ_OFS, 0);
        chk(q & 32'h4, 32'h4);
        repeat (20) @(posedge pclk);
        bus(0, MMS_IRQ_OFS, 0);
        chk(q & 32'h2, 32'h0);
        bus(1, MMS_CTRL_OFS, S_MB | B_GO);
        repeat (20) @(posedge pclk);
        chk(irq, 1'b1);
        // mask before the clearing read, so the low level proves the mask
        bus(1, MMS_MASK_OFS, 32'h0);
        #1;
        chk(irq, 1'b0);
        bus(0, MMS_IRQ_OFS, 0);
        chk(q & 32'h2, 32'h2);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        bus(0, MMS_CHKB_OFS, 0);
        chk(q, 32'h0);
        report_and_stop();
    end
endmodule
